// [core/dual_octal_gpio_port_defines.vh]
// register map, reset values and mode codes for the dual octal gpio port
`ifndef DUAL_OCTAL_GPIO_PORT_DEFINES_VH
`define DUAL_OCTAL_GPIO_PORT_DEFINES_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define SEV_DATA_IDX 16'hFFDA
`define EIG_DATA_IDX 16'hFFDB
`define SEV_DIR_IDX 16'hFFEA
`define EIG_DIR_IDX 16'hFFEB
`define PWR_MODE_IDX 16'hFFF0

// ----------------------------------------
// reset values and read constants
// ----------------------------------------
`define DATA_RST 8'h00
`define DIR_RST 8'h00
`define WO_READ 8'hFF
`define MODE_RST 3'h0

// ----------------------------------------
// operating mode codes
// ----------------------------------------
`define MODE_ACTIVE 3'h0
`define MODE_SUBACTIVE 3'h1
`define MODE_SLEEP 3'h2
`define MODE_SUBSLEEP 3'h3
`define MODE_WATCH 3'h4
`define MODE_STANDBY 3'h5

// ----------------------------------------
// axi responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [core/dual_octal_gpio_port.v]
// two 8-bit gpio ports with data and write-only direction registers, axi4-lite slave
`timescale 1ns/1ps
`include "dual_octal_gpio_port_defines.vh"

// Summary of operation
// RQ1: port seven has eight pins, each with data and direction bits.
// RQ2: port eight has eight pins, each with data and direction bits.
// RQ3: port-seven output pins read back the latched data bit.
// RQ4: port-seven input pins read back the live pin level.
// RQ5: port-seven direction 1 drives data on pin; 0 makes it input.
// RQ6: port-seven data register resets to zero.
// RQ7: port-seven direction register resets to zero, all pins inputs.
// RQ8: port-seven direction register is write-only and reads all ones.
// RQ9: port-eight output pins read back the latched data bit.
// RQ10: port-eight input pins read back the live pin level.
// RQ11: port-eight direction 1 drives data on pin; 0 makes it input.
// RQ12: port-eight data register resets to zero.
// RQ13: port-eight direction register resets to zero, all pins inputs.
// RQ14: port-eight direction register is write-only and reads all ones.
// RQ15: port-seven pins float in reset/standby, hold in sleep modes, else run; the code also floats them for mode codes 6 and 7.
// RQ16: port-eight pins float in reset/standby, hold in sleep modes, else run; the code also floats them for mode codes 6 and 7.
// RQ17: each pin's direction affects only that pin and its read bit.
module dual_octal_gpio_port #(
	parameter WIDTH = 8
)
(
	// clock and reset
	input wire clk_sys_i,
	input wire rst_b_i,
	// axi4-lite write address
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_awaddr,
	// axi4-lite write data
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	// axi4-lite write response
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	output wire [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	input wire [31:0] s_axi_araddr,
	// axi4-lite read data
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	// port seven pins
	input wire [WIDTH-1:0] seventh_port_pins_i,
	output wire [WIDTH-1:0] seventh_port_pins_o,
	output wire [WIDTH-1:0] seventh_port_pins_oe_o,
	// port eight pins
	input wire [WIDTH-1:0] eighth_port_pins_i,
	output wire [WIDTH-1:0] eighth_port_pins_o,
	output wire [WIDTH-1:0] eighth_port_pins_oe_o
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// per-bit readback select: latched data where output, live pin where input
	function [WIDTH-1:0] port_read;
		input [WIDTH-1:0] data;
		input [WIDTH-1:0] dir;
		input [WIDTH-1:0] pin;
		begin
			port_read = (data & dir) | (pin & ~dir);
		end
	endfunction

	// byte address to register index, low two bits dropped
	function [15:0] reg_index;
		input [31:0] addr;
		begin
			reg_index = addr[17:2];
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [WIDTH-1:0] sev_data_ff;
	reg [WIDTH-1:0] eig_data_ff;
	reg [WIDTH-1:0] sev_dir_ff;
	reg [WIDTH-1:0] eig_dir_ff;
	reg [2:0] mode_ff;
	reg [WIDTH-1:0] sev_sync1_ff;
	reg [WIDTH-1:0] sev_sync2_ff;
	reg [WIDTH-1:0] eig_sync1_ff;
	reg [WIDTH-1:0] eig_sync2_ff;
	reg [WIDTH-1:0] sev_out_ff;
	reg [WIDTH-1:0] sev_oe_ff;
	reg [WIDTH-1:0] eig_out_ff;
	reg [WIDTH-1:0] eig_oe_ff;
	reg awready_ff;
	reg wready_ff;
	reg arready_ff;
	reg aw_held_ff;
	reg w_held_ff;
	reg [31:0] awaddr_ff;
	reg [31:0] wdata_ff;
	reg [3:0] wstrb_ff;
	reg bvalid_ff;
	reg [1:0] bresp_ff;
	reg rvalid_ff;
	reg [31:0] rdata_ff;
	reg [1:0] rresp_ff;
	reg [WIDTH-1:0] nxt_sev_out;
	reg [WIDTH-1:0] nxt_sev_oe;
	reg [WIDTH-1:0] nxt_eig_out;
	reg [WIDTH-1:0] nxt_eig_oe;
	reg [31:0] nxt_rdata;
	reg [1:0] nxt_rresp;

	wire aw_take;
	wire w_take;
	wire wr_go;
	wire rd_take;
	wire [15:0] wr_idx;
	wire [15:0] rd_idx;
	wire byte0_en;

	// ----------------------------------------
	// axi4-lite handshakes
	// ----------------------------------------
	// one write in flight: address and data are parked until the response drains
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign wr_go = aw_held_ff & w_held_ff;
	assign wr_idx = reg_index(awaddr_ff);
	assign byte0_en = wstrb_ff[0];
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	assign s_axi_arready = arready_ff;
	assign rd_take = s_axi_arvalid & s_axi_arready;
	assign rd_idx = reg_index(s_axi_araddr);
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= 32'h0000_0000;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				case (wr_idx)
					`SEV_DATA_IDX, `EIG_DATA_IDX, `SEV_DIR_IDX, `EIG_DIR_IDX, `PWR_MODE_IDX:
						bresp_ff <= `RESP_OKAY;
					default:
						bresp_ff <= `RESP_SLVERR;
				endcase
			end
			else if (bvalid_ff && s_axi_bready)
			begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sev_data_ff <= `DATA_RST; // see RQ6
			sev_dir_ff <= `DIR_RST; // see RQ7
			eig_data_ff <= `DATA_RST; // see RQ12
			eig_dir_ff <= `DIR_RST; // see RQ13
			mode_ff <= `MODE_RST;
		end
		else if (wr_go && byte0_en)
		begin
			// only the low byte lane carries register bits
			case (wr_idx)
				`SEV_DATA_IDX: sev_data_ff <= wdata_ff[WIDTH-1:0]; // see RQ1
				`EIG_DATA_IDX: eig_data_ff <= wdata_ff[WIDTH-1:0]; // see RQ2
				`SEV_DIR_IDX: sev_dir_ff <= wdata_ff[WIDTH-1:0]; // see RQ1
				`EIG_DIR_IDX: eig_dir_ff <= wdata_ff[WIDTH-1:0]; // see RQ2
				`PWR_MODE_IDX: mode_ff <= wdata_ff[2:0];
				default: mode_ff <= mode_ff;
			endcase
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sev_sync1_ff <= {WIDTH{1'b0}};
			sev_sync2_ff <= {WIDTH{1'b0}};
			eig_sync1_ff <= {WIDTH{1'b0}};
			eig_sync2_ff <= {WIDTH{1'b0}};
		end
		else
		begin
			sev_sync1_ff <= seventh_port_pins_i;
			sev_sync2_ff <= sev_sync1_ff;
			eig_sync1_ff <= eighth_port_pins_i;
			eig_sync2_ff <= eig_sync1_ff;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		nxt_rresp = `RESP_OKAY;
		case (rd_idx)
			`SEV_DATA_IDX:
				nxt_rdata[WIDTH-1:0] = port_read(sev_data_ff, sev_dir_ff, sev_sync2_ff); // see RQ3 RQ4 RQ17
			`EIG_DATA_IDX:
				nxt_rdata[WIDTH-1:0] = port_read(eig_data_ff, eig_dir_ff, eig_sync2_ff); // see RQ9 RQ10 RQ17
			`SEV_DIR_IDX:
				nxt_rdata[WIDTH-1:0] = `WO_READ; // see RQ8
			`EIG_DIR_IDX:
				nxt_rdata[WIDTH-1:0] = `WO_READ; // see RQ14
			`PWR_MODE_IDX:
				nxt_rdata[2:0] = mode_ff;
			default:
				nxt_rresp = `RESP_SLVERR;
		endcase
	end

	always @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `RESP_OKAY;
		end
		else if (rd_take)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
		else if (rvalid_ff && s_axi_rready)
		begin
			rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// ready flags
	// ----------------------------------------
	// flops rather than gates, so every bus output comes straight from a register
	always @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			arready_ff <= 1'b1;
		end
		else
		begin
			if (aw_take)
			begin
				awready_ff <= 1'b0;
			end
			else if (bvalid_ff && s_axi_bready)
			begin
				awready_ff <= 1'b1;
			end
			if (w_take)
			begin
				wready_ff <= 1'b0;
			end
			else if (bvalid_ff && s_axi_bready)
			begin
				wready_ff <= 1'b1;
			end
			if (rd_take)
			begin
				arready_ff <= 1'b0;
			end
			else if (rvalid_ff && s_axi_rready)
			begin
				arready_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// pin drivers by operating mode
	// ----------------------------------------
	// sleep-type modes freeze the drivers, so register writes there show up on wake
	always @*
	begin
		nxt_sev_out = sev_out_ff;
		nxt_sev_oe = sev_oe_ff;
		nxt_eig_out = eig_out_ff;
		nxt_eig_oe = eig_oe_ff;
		case (mode_ff)
			`MODE_ACTIVE, `MODE_SUBACTIVE:
			begin
				nxt_sev_out = sev_data_ff & sev_dir_ff; // see RQ5 RQ15 RQ17
				nxt_sev_oe = sev_dir_ff; // see RQ5
				nxt_eig_out = eig_data_ff & eig_dir_ff; // see RQ11 RQ16 RQ17
				nxt_eig_oe = eig_dir_ff; // see RQ11
			end
			`MODE_SLEEP, `MODE_SUBSLEEP, `MODE_WATCH:
			begin
				nxt_sev_oe = sev_oe_ff; // see RQ15
				nxt_eig_oe = eig_oe_ff; // see RQ16
			end
			`MODE_STANDBY:
			begin
				nxt_sev_oe = {WIDTH{1'b0}}; // see RQ15
				nxt_eig_oe = {WIDTH{1'b0}}; // see RQ16
			end
			default:
			begin
				nxt_sev_oe = {WIDTH{1'b0}};
				nxt_eig_oe = {WIDTH{1'b0}};
			end
		endcase
	end

	always @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			// floating while reset is held
			sev_out_ff <= {WIDTH{1'b0}}; // see RQ15
			sev_oe_ff <= {WIDTH{1'b0}};
			eig_out_ff <= {WIDTH{1'b0}}; // see RQ16
			eig_oe_ff <= {WIDTH{1'b0}};
		end
		else
		begin
			sev_out_ff <= nxt_sev_out;
			sev_oe_ff <= nxt_sev_oe;
			eig_out_ff <= nxt_eig_out;
			eig_oe_ff <= nxt_eig_oe;
		end
	end

	assign seventh_port_pins_o = sev_out_ff;
	assign seventh_port_pins_oe_o = sev_oe_ff;
	assign eighth_port_pins_o = eig_out_ff;
	assign eighth_port_pins_oe_o = eig_oe_ff;

endmodule // dual_octal_gpio_port

// [dv/dual_octal_gpio_port_asserts.sv]
// concurrent checks on the bus and pin enables of the dual octal gpio port
`timescale 1ns/1ps
module dual_octal_gpio_port_asserts #(
	parameter WIDTH = 8
)
(
	// clock and reset
	input wire clk_sys_i,
	input wire rst_b_i,
	// register bus
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// pin enables
	input wire [WIDTH-1:0] seventh_port_pins_oe_o,
	input wire [WIDTH-1:0] eighth_port_pins_oe_o
);
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!rst_b_i);
// upper address bits alias, so only the index field decides
wire ar_hit = s_axi_arvalid && s_axi_arready;
wire dir_rd = ar_hit && (s_axi_araddr[17:2] == 16'hFFEA || s_axi_araddr[17:2] == 16'hFFEB);
a_float_reset: assert property ($rose(rst_b_i) |->
	seventh_port_pins_oe_o == '0 && eighth_port_pins_oe_o == '0)
	else $error("pins driven at reset release");
a_dir_ones: assert property (dir_rd |=> s_axi_rdata[7:0] == 8'hFF)
	else $error("direction read not all ones");
a_read_answer: assert property (ar_hit |=> s_axi_rvalid)
	else $error("read answer late");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
	s_axi_rvalid && $stable(s_axi_rdata))
	else $error("read data dropped");
a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("read taken while answer pending");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
	else $error("write response dropped");
a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
	else $error("write taken while response pending");
a_b_drain: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
	else $error("write response repeated");
c_dir_read: cover property (dir_rd);
c_write_done: cover property (s_axi_bvalid && s_axi_bready);
c_pins_float: cover property ($fell(|seventh_port_pins_oe_o));
endmodule // dual_octal_gpio_port_asserts

// [dv/gpio_pin_board.sv]
// board-side model of the eight pins of one port
`timescale 1ns/1ps
module gpio_pin_board (
	// from the port
	input wire [7:0] drv_i,
	input wire [7:0] drv_oe_i,
	// board side
	input wire [7:0] ext_i,
	output wire [7:0] level_o
);
// a released pin follows the board's own signal, never the port's last value
assign level_o = (drv_oe_i & drv_i) | (~drv_oe_i & ext_i);
endmodule // gpio_pin_board

// [dv/dual_octal_gpio_port_bench.sv]
// register-level bench for the dual octal gpio port
`timescale 1ns/1ps
module dual_octal_gpio_port_bench;
logic clk = 0, rst_b = 0;
logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
wire awready, wready, bvalid, arready, rvalid;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
logic [7:0] ext7 = 8'hA5, ext8 = 8'h3C, hold;
wire [7:0] lv7, lv8, o7, o8, oe7, oe8;
int num_errors = 0, n_tests = 0;
always #5 clk = ~clk;
dual_octal_gpio_port #(.WIDTH(8)) uut (.clk_sys_i(clk), .rst_b_i(rst_b),
	.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
	.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
	.s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
	.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
	.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
	.s_axi_rdata(rdata), .s_axi_rresp(rresp), .seventh_port_pins_i(lv7),
	.seventh_port_pins_o(o7), .seventh_port_pins_oe_o(oe7),
	.eighth_port_pins_i(lv8), .eighth_port_pins_o(o8), .eighth_port_pins_oe_o(oe8));
gpio_pin_board b7 (.drv_i(o7), .drv_oe_i(oe7), .ext_i(ext7), .level_o(lv7));
gpio_pin_board b8 (.drv_i(o8), .drv_oe_i(oe8), .ext_i(ext8), .level_o(lv8));
task chk(input [31:0] got, input [31:0] exp);
	n_tests++;
	if (got !== exp)
	begin
		num_errors++;
		$display("mismatch at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task wr(input [15:0] idx, input [7:0] d, input [1:0] er);
	logic a, w, b;
	logic [1:0] r;
	awaddr <= {14'h0000, idx, 2'b00};
	wdata <= {24'h00_0000, d};
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	do
	begin
		@(negedge clk);
		a = awready;
		w = wready;
		b = bvalid;
		r = bresp;
		@(posedge clk);
		if (a) awvalid <= 1'b0;
		if (w) wvalid <= 1'b0;
		// bready stays up: dropping it here clashes with the next call's raise
	end while (!b);
	chk(r, er);
endtask
task rd(input [15:0] idx, input [31:0] exp, input [1:0] er);
	logic a, b;
	logic [31:0] v;
	logic [1:0] r;
	araddr <= {14'h0000, idx, 2'b00};
	arvalid <= 1'b1;
	rready <= 1'b1;
	do
	begin
		@(negedge clk);
		a = arready;
		b = rvalid;
		v = rdata;
		r = rresp;
		@(posedge clk);
		if (a) arvalid <= 1'b0;
	end while (!b);
	chk(v, exp);
	chk(r, er);
endtask
task test_done;
	$display("tests %0d errors %0d", n_tests, num_errors);
	if (num_errors == 0 && n_tests > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
initial
begin
	repeat (5000) @(posedge clk);
	num_errors++;
	test_done;
end
initial
begin
	repeat (16) @(posedge clk);
	rst_b <= 1'b1;
	@(posedge clk);
	chk({oe8, oe7}, 32'h0);
	rd(16'hFFEA, 32'h0000_00FF, 2'h0);
	rd(16'hFFEB, 32'h0000_00FF, 2'h0);
	rd(16'hFFDA, {24'h0, ext7}, 2'h0);
	rd(16'hFFDB, {24'h0, ext8}, 2'h0);
	wr(16'hFFEA, 8'hFF, 2'h0);
	rd(16'hFFDA, 32'h0, 2'h0);
	wr(16'hFFEB, 8'hFF, 2'h0);
	rd(16'hFFDB, 32'h0, 2'h0);
	wr(16'hFFDA, 8'h5A, 2'h0);
	wr(16'hFFDB, 8'hC3, 2'h0);
	wr(16'hFFEA, 8'h0F, 2'h0);
	wr(16'hFFEB, 8'hF0, 2'h0);
	rd(16'hFFEA, 32'h0000_00FF, 2'h0);
	rd(16'hFFEB, 32'h0000_00FF, 2'h0);
	repeat (2) @(posedge clk);
	chk({oe7, o7 & oe7}, 32'h0F0A);
	chk({oe8, o8 & oe8}, 32'hF0C0);
	rd(16'hFFDA, 32'h0000_00AA, 2'h0);
	rd(16'hFFDB, 32'h0000_00CC, 2'h0);
	// unmapped place answers with an error both ways
	rd(16'h0100, 32'h0, 2'h2);
	wr(16'h0100, 8'h00, 2'h2);
	// walk every operating mode code with port seven all outputs
	wr(16'hFFEA, 8'hFF, 2'h0);
	for (int m = 0; m < 8; m++)
	begin
		wr(16'hFFF0, 8'(m), 2'h0);
		wr(16'hFFDA, 8'(8'h10 + m), 2'h0);
		if (m < 2) hold = 8'(8'h10 + m);
		repeat (2) @(posedge clk);
		chk({oe8, oe7, o7 & oe7}, m >= 5 ? 32'h0 : {8'h0, 8'hF0, 8'hFF, hold});
	end
	wr(16'hFFF0, 8'h00, 2'h0);
	test_done;
end
endmodule // dual_octal_gpio_port_bench
bind dual_octal_gpio_port dual_octal_gpio_port_asserts #(.WIDTH(WIDTH)) u_chk (
	.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.seventh_port_pins_oe_o(seventh_port_pins_oe_o),
	.eighth_port_pins_oe_o(eighth_port_pins_oe_o));
